// *** design/host_port_pkg.sv ***
// Constants, types and carriers shared by the dual channel host bus port
`default_nettype none

package host_port_pkg;

  // ==========================================================
  // Channel count and register addresses inside a channel
  localparam int NUM_CHAN = 2;
  localparam int ADDR_W = 3;
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_FIFO_CTL = 3'h2;
  localparam logic [2:0] REG_MODEM_CTL = 3'h4;
  localparam logic [2:0] REG_LINE_STAT = 3'h5;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // ==========================================================
  // Field positions
  localparam int MCR_IRQ_EN_BIT = 3;
  localparam int FCR_FIFO_EN_BIT = 0;
  localparam int FCR_RDY_MODE_BIT = 3;
  localparam int FCR_TRIG_LSB = 6;

  // ==========================================================
  // FIFO depth and receive trigger levels
  localparam int FIFO_DEPTH = 16;
  localparam int LEVEL_W = 5;
  localparam logic [4:0] TRIG_LEVEL_0 = 5'h01;
  localparam logic [4:0] TRIG_LEVEL_1 = 5'h04;
  localparam logic [4:0] TRIG_LEVEL_2 = 5'h08;
  localparam logic [4:0] TRIG_LEVEL_3 = 5'h0e;

  // ==========================================================
  // Access phase of the host bus
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_READ = 2'b01,
    PH_WRITE = 2'b10
  } access_phase_t;

  // ==========================================================
  // Status coming from one channel's UART core
  typedef struct packed {
    logic [7:0] rxData;
    logic [7:0] lineStatus;
    logic irqReq;
    logic [LEVEL_W-1:0] txLevel;
    logic [LEVEL_W-1:0] rxLevel;
  } chan_core_t;

  // Controls going to one channel's UART core
  typedef struct packed {
    logic txPush;
    logic rxPop;
    logic [7:0] txData;
    logic [7:0] fifoCtl;
    logic [7:0] modemCtl;
  } chan_ctl_t;

endpackage : host_port_pkg

`default_nettype wire

// *** design/chan_ready.sv ***
// Transmit and receive ready flags of one channel
`default_nettype none

module chan_ready
  import host_port_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Configuration and fill levels
  input wire logic [7:0] fifoCtl,
  input wire logic [LEVEL_W-1:0] txLevel,
  input wire logic [LEVEL_W-1:0] rxLevel,
  // Active low ready flags
  output logic txReadyN,
  output logic rxReadyN
);

  typedef struct packed {
    logic txN;
    logic rxN;
  } ready_state_t;

  ready_state_t st;
  ready_state_t nxt;
  logic [LEVEL_W-1:0] trig;
  logic fifoOn;
  logic burst;

  // ==========================================================
  // Ready conditions per FIFO mode and trigger level
  always_comb
  begin
    nxt = st;
    fifoOn = fifoCtl[FCR_FIFO_EN_BIT];
    burst = fifoOn & fifoCtl[FCR_RDY_MODE_BIT];
    case (fifoCtl[FCR_TRIG_LSB +: 2])
      2'h0: trig = TRIG_LEVEL_0;
      2'h1: trig = TRIG_LEVEL_1;
      2'h2: trig = TRIG_LEVEL_2;
      default: trig = TRIG_LEVEL_3;
    endcase
    if (burst)
    begin
      nxt.rxN = ~(rxLevel >= trig);
      nxt.txN = ~(txLevel < LEVEL_W'(DEPTH));
    end
    else
    begin
      nxt.rxN = ~(rxLevel != '0);
      nxt.txN = ~(txLevel == '0);
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      st.txN <= 1'b0;
      st.rxN <= 1'b1;
    end
    else
      st <= nxt;
  end

  assign txReadyN = st.txN;
  assign rxReadyN = st.rxN;

endmodule : chan_ready

`default_nettype wire

// *** design/dual_uart_host_bus_port.sv ***
// Host bus port of a dual channel UART: decode, registers, pins
`default_nettype none


module dual_uart_host_bus_port
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bus style and strobes
  input wire logic busStyleSel,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  // Address and data bus
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  // Interrupt pins, output and enable each
  output logic chan_a_irq,
  output logic chan_a_irq_oe,
  output logic chan_b_irq,
  output logic chan_b_irq_oe,
  // Auxiliary outputs
  output logic aux_out_a_n,
  output logic aux_out_b_n,
  // Ready flags
  output logic tx_ready_a_n,
  output logic rx_ready_a_n,
  output logic tx_ready_b_n,
  output logic rx_ready_b_n,
  // UART core side
  input wire chan_core_t [NUM_CHAN-1:0] coreStat,
  output wire chan_ctl_t [NUM_CHAN-1:0] coreCtl
);

  // ==========================================================
  // Module state
  typedef struct packed {
    // Sequencer and the target latched when an access is taken
    access_phase_t phase;
    logic chan;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wrData;
    // Byte driven on the bus during a read
    logic [7:0] dataOut;
    logic dataOe;
    // One cycle strobes and the byte handed to the transmitter
    logic [NUM_CHAN-1:0] txPush;
    logic [NUM_CHAN-1:0] rxPop;
    logic [NUM_CHAN-1:0][7:0] txData;
    // Stored register bytes per channel
    logic [NUM_CHAN-1:0][7:0][7:0] regs;
  } port_state_t;

  port_state_t st;
  port_state_t nxt;

  // ==========================================================
  // Decoded request of the current bus cycle
  logic rdAct;
  logic wrAct;
  logic accChan;
  logic selA;
  logic selB;
  logic anySel;

  // Byte offered to a read
  logic [7:0] rdByte;

  // Per channel enables, requests and ready flags
  logic [NUM_CHAN-1:0] irqEn;
  logic [NUM_CHAN-1:0] irqReq;
  logic [NUM_CHAN-1:0] txRdyN;
  logic [NUM_CHAN-1:0] rxRdyN;

  // Open drain request of the whole device
  logic devIrqOe;

  // ==========================================================
  // Access decode for both bus styles
  always_comb
  begin
    selA = ~chan_a_select_n;
    selB = ~chan_b_select_n;
    anySel = selA | selB;
    if (busStyleSel)
    begin
      // Separate strobes, one select per channel; A wins if both low,
      // so a host that shows both selects never splits one access
      rdAct = ~read_strobe_n & anySel;
      wrAct = ~write_strobe_n & anySel;
      accChan = ~selA;
      if (!anySel)
        accChan = 1'b0;
    end
    else
    begin
      // Read strobe pin is not looked at in this style
      rdAct = selA & write_strobe_n;
      wrAct = selA & ~write_strobe_n;
      accChan = chan_b_select_n;
    end
  end

  // ==========================================================
  // Read data select: data port pops the receiver, status is live
  // Only the byte seen at the taking edge is kept; later changes are ignored
  always_comb
  begin
    case (regAddr)
      REG_DATA: rdByte = coreStat[accChan].rxData;
      REG_LINE_STAT: rdByte = coreStat[accChan].lineStatus;
      default: rdByte = st.regs[accChan][regAddr];
    endcase
  end

  // ==========================================================
  // Access sequencer
  always_comb
  begin
    nxt = st;
    nxt.txPush = '0;
    nxt.rxPop = '0;
    case (st.phase)
      PH_IDLE:
      begin
        nxt.dataOe = 1'b0;
        // Read wins if a host shows both requests at once
        if (rdAct)
        begin
          // Strobe fall: fetch the byte and start driving the bus
          nxt.phase = PH_READ;
          nxt.chan = accChan;
          nxt.addr = regAddr;
          nxt.dataOut = rdByte;
          nxt.dataOe = 1'b1;
          // A data port read pops the receiver once per access
          if (regAddr == REG_DATA)
            nxt.rxPop[accChan] = 1'b1;
        end
        else if (wrAct)
        begin
          // Strobe fall: open the write cycle and note its target
          nxt.phase = PH_WRITE;
          nxt.chan = accChan;
          nxt.addr = regAddr;
          nxt.wrData = dataIn;
        end
      end
      PH_READ:
      begin
        // Hold the byte until the strobe or select is released
        if (!rdAct)
        begin
          nxt.phase = PH_IDLE;
          nxt.dataOe = 1'b0;
        end
        else
          nxt.dataOe = 1'b1;
      end
      PH_WRITE:
      begin
        // Keep sampling: the byte that counts is the one at the rise
        if (wrAct)
          nxt.wrData = dataIn;
        else
        begin
          // Strobe rise: store the last byte seen on the bus
          nxt.phase = PH_IDLE;
          // Data port writes go to the transmitter, not to storage
          if (st.addr == REG_DATA)
          begin
            nxt.txPush[st.chan] = 1'b1;
            nxt.txData[st.chan] = st.wrData;
          end
          else
            nxt.regs[st.chan][st.addr] = st.wrData;
        end
      end
      default:
      begin
        // Unused phase code: back to idle with the bus released
        nxt.phase = PH_IDLE;
        nxt.dataOe = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      // Clearing every byte leaves bit 3 low: irq pins float, aux high
      st <= '0;
      st.phase <= PH_IDLE;
      st.regs <= {(NUM_CHAN * 8){REG_RESET_VAL}};
    end
    else
      st <= nxt;
  end

  // ==========================================================
  // Data bus outputs
  // Registered, so the byte stands still at the host's sampling edge
  assign dataOut = st.dataOut;
  assign dataOe = st.dataOe;

  // ==========================================================
  // Per channel ready flags and core controls
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++)
    begin : g_chan
      // Interrupt enable and request of this channel
      assign irqEn[ch] = st.regs[ch][REG_MODEM_CTL][MCR_IRQ_EN_BIT];
      assign irqReq[ch] = coreStat[ch].irqReq;

      // Core controls come straight from the stored bytes
      assign coreCtl[ch].txPush = st.txPush[ch];
      assign coreCtl[ch].rxPop = st.rxPop[ch];
      assign coreCtl[ch].txData = st.txData[ch];
      assign coreCtl[ch].fifoCtl = st.regs[ch][REG_FIFO_CTL];
      assign coreCtl[ch].modemCtl = st.regs[ch][REG_MODEM_CTL];

      // Ready logic is configured separately in each channel
      chan_ready #(
        .DEPTH(FIFO_DEPTH)
      ) u_ready (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .fifoCtl(st.regs[ch][REG_FIFO_CTL]),
        .txLevel(coreStat[ch].txLevel),
        .rxLevel(coreStat[ch].rxLevel),
        .txReadyN(txRdyN[ch]),
        .rxReadyN(rxRdyN[ch])
      );
    end
  endgenerate

  // ==========================================================
  // Ready pins; index 0 is channel A, index 1 channel B
  assign tx_ready_a_n = txRdyN[0];
  assign rx_ready_a_n = rxRdyN[0];
  assign tx_ready_b_n = txRdyN[1];
  assign rx_ready_b_n = rxRdyN[1];

  // ==========================================================
  // Auxiliary outputs mirror the interrupt enable bit inverted
  // In the separate strobe style, aux goes low exactly while the interrupt pin is enabled
  assign aux_out_a_n = ~irqEn[0];
  assign aux_out_b_n = ~irqEn[1];

  // ==========================================================
  // Combined request: any channel that is enabled and asking
  assign devIrqOe = |(irqEn & irqReq);

  // ==========================================================
  // Interrupt pins for both styles
  always_comb
  begin
    if (busStyleSel)
    begin
      // Per channel, active high, floating while disabled
      chan_a_irq = irqReq[0];
      chan_a_irq_oe = irqEn[0];
      chan_b_irq = irqReq[1];
      chan_b_irq_oe = irqEn[1];
    end
    else
    begin
      // Open drain: pull low while any enabled channel requests
      chan_a_irq = 1'b0;
      chan_a_irq_oe = devIrqOe;
      chan_b_irq = 1'b0;
      chan_b_irq_oe = 1'b0;
    end
  end

endmodule : dual_uart_host_bus_port

`default_nettype wire

// *** verif/host_port_chk_asserts.sv ***
// Checker for the host bus port pins
`default_nettype none

module host_port_chk
  import host_port_pkg::*;
(
  // Watched pins
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic busStyleSel,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic chan_a_irq,
  input wire logic chan_a_irq_oe,
  input wire logic chan_b_irq_oe,
  input wire logic aux_out_a_n,
  input wire logic aux_out_b_n,
  input wire logic rx_ready_a_n,
  input wire chan_core_t [NUM_CHAN-1:0] coreStat,
  input wire chan_ctl_t [NUM_CHAN-1:0] coreCtl
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Read request as decoded from either bus style
  logic rd;
  assign rd = busStyleSel ?
    !read_strobe_n && !(chan_a_select_n && chan_b_select_n) :
    !chan_a_select_n && write_strobe_n;

  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Steps of a read
  sequence rdTaken;
    !dataOe && rd;
  endsequence
  sequence rdDone;
    dataOe && !rd;
  endsequence

  read_start_a: assert property (rdTaken |=> dataOe)
    else $error("read not answered");
  read_hold_a: assert property (
    dataOe && rd |=> dataOe && $stable(dataOut))
    else $error("read byte not held");
  read_end_a: assert property (rdDone |=> !dataOe)
    else $error("bus driven after read");
  bus_quiet_a: assert property (!dataOe && !rd |=> !dataOe)
    else $error("bus driven without select");
  aux_a_a: assert property (
    busStyleSel |-> aux_out_a_n != chan_a_irq_oe)
    else $error("aux A and irq A disagree");
  aux_b_a: assert property (
    busStyleSel |-> aux_out_b_n != chan_b_irq_oe)
    else $error("aux B and irq B disagree");
  irq_open_a: assert property (
    !busStyleSel |-> !chan_a_irq && !chan_b_irq_oe)
    else $error("combined irq not open drain");
  irq_reset_a: assert property (
    $rose(reset_n) |-> !chan_b_irq_oe && aux_out_b_n)
    else $error("irq B driven after reset");
  push_pulse_a: assert property (
    coreCtl[0].txPush |=> !coreCtl[0].txPush)
    else $error("push longer than a cycle");
  rx_ready_a: assert property (!coreCtl[0].fifoCtl[0] |=>
    rx_ready_a_n == ($past(coreStat[0].rxLevel) == 5'h00))
    else $error("rx ready A wrong");
endmodule : host_port_chk

bind dual_uart_host_bus_port host_port_chk host_port_chk_i (.sys_clk,
  .reset_n, .busStyleSel, .read_strobe_n, .write_strobe_n, .chan_a_select_n,
  .chan_b_select_n, .dataOut, .dataOe, .chan_a_irq, .chan_a_irq_oe,
  .chan_b_irq_oe, .aux_out_a_n, .aux_out_b_n, .rx_ready_a_n, .coreStat,
  .coreCtl);

`default_nettype wire

// *** verif/uart_core_model.sv ***
// Behavioural UART core of one channel
`default_nettype none

module uart_core_model
  import host_port_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Port side
  input wire chan_ctl_t ctl,
  output var chan_core_t stat,
  // Bench stimulus
  input wire logic rxLoad,
  input wire logic [7:0] rxByte,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;

  // Tx level counts pushes; a load sets rx level to 1, a pop sets it to 0; a popped byte is not kept
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      stat <= '0;
    end
    else
    begin
      stat.irqReq <= irq;
      if (ctl.txPush)
      begin
        stat.txLevel <= stat.txLevel + 5'h01;
      end
      if (rxLoad)
      begin
        stat.rxData <= rxByte;
        stat.rxLevel <= 5'h01;
      end
      else if (ctl.rxPop)
      begin
        stat.rxData <= ~stat.rxData; // Stale byte flipped
        stat.rxLevel <= 5'h00;
      end
    end
  end
endmodule : uart_core_model

`default_nettype wire

// *** verif/dual_uart_host_bus_port_tb.sv ***
// Self-checking bench for the dual channel host bus port
`default_nettype none

module dual_uart_host_bus_port_tb
  import host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Pins, core side and scoreboard
  logic sys_clk, reset_n, busStyleSel, read_strobe_n, write_strobe_n;
  logic chan_a_select_n, chan_b_select_n, dataOe;
  logic [2:0] regAddr;
  logic [7:0] dataIn, dataOut, q, b;
  logic chan_a_irq, chan_a_irq_oe, chan_b_irq, chan_b_irq_oe;
  logic aux_out_a_n, aux_out_b_n, tx_ready_a_n, rx_ready_a_n;
  logic tx_ready_b_n, rx_ready_b_n;
  logic [1:0] rxLoad, irqReq;
  logic [31:0] rnd;
  logic [7:0] mem[2][8];
  logic [7:0] rxQ[$];
  logic [2:0] sc[4] = '{3'h1, 3'h3, 3'h6, 3'h7};
  wire chan_core_t [1:0] coreStat;
  wire chan_ctl_t [1:0] coreCtl;
  int errors, nCompared, txCnt[2];

  dual_uart_host_bus_port dual_uart_host_bus_port_i (.sys_clk, .reset_n,
    .busStyleSel, .read_strobe_n, .write_strobe_n, .chan_a_select_n,
    .chan_b_select_n, .regAddr, .dataIn, .dataOut, .dataOe, .chan_a_irq,
    .chan_a_irq_oe, .chan_b_irq, .chan_b_irq_oe, .aux_out_a_n, .aux_out_b_n,
    .tx_ready_a_n, .rx_ready_a_n, .tx_ready_b_n, .rx_ready_b_n, .coreStat,
    .coreCtl);

  // One core model per channel
  for (genvar c = 0; c < 2; c++)
  begin : g_core
    uart_core_model uart_core_model_i (.sys_clk, .reset_n, .ctl(coreCtl[c]),
      .stat(coreStat[c]), .rxLoad(rxLoad[c]), .rxByte(b), .irq(irqReq[c]));
  end

  // 25 MHz clock
  always #20 sys_clk = !sys_clk;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One bus access, strobe held two cycles, then two idle edges
  task automatic acc(input logic ch, input logic wr, input logic [2:0] a,
    input logic [7:0] d, output logic [7:0] rq);
    @(posedge sys_clk);
    regAddr <= a;
    dataIn <= d;
    write_strobe_n <= !wr;
    if (busStyleSel)
    begin
      chan_a_select_n <= ch;
      chan_b_select_n <= !ch;
      read_strobe_n <= wr;
    end
    else
    begin
      chan_a_select_n <= 1'b0;
      chan_b_select_n <= ch;
    end
    repeat (2) @(posedge sys_clk);
    rq = dataOut;
    chk(dataOe, !wr);
    {chan_a_select_n, chan_b_select_n, read_strobe_n} <= 3'h7;
    write_strobe_n <= 1'b1;
    dataIn <= ~d;
    repeat (2) @(posedge sys_clk);
  endtask : acc

  task automatic tally_and_finish;
    $display("errors %0d compared %0d", errors, nCompared);
    if (errors == 0 && nCompared > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Main sequence
  initial
  begin
    {sys_clk, reset_n, busStyleSel, read_strobe_n, write_strobe_n} = 5'h07;
    {chan_a_select_n, chan_b_select_n, regAddr, dataIn, b} = '1;
    {rxLoad, irqReq} = '0;
    errors = 0;
    nCompared = 0;
    txCnt = '{0, 0};
    rnd = 32'h36699f5e;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({aux_out_a_n, aux_out_b_n, chan_a_irq_oe, chan_b_irq_oe,
      tx_ready_a_n, tx_ready_b_n, rx_ready_a_n, rx_ready_b_n}, 8'hc3);
    read_strobe_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(dataOe, 1'b0);
    read_strobe_n <= 1'b1;
    for (int s = 1; s >= 0; s--)
    begin
      busStyleSel <= s[0];
      for (int ch = 0; ch < 2; ch++)
      begin
        foreach (sc[i])
        begin
          rnd = lfsr(rnd);
          mem[ch][sc[i]] = rnd[7:0];
          acc(ch[0], 1'b1, sc[i], rnd[7:0], q);
        end
        foreach (sc[i])
        begin
          acc(ch[0], 1'b0, sc[i], 8'h00, q);
          chk(q, mem[ch][sc[i]]);
        end
        // Status address reads the core, not the byte stored there
        rnd = lfsr(rnd);
        acc(ch[0], 1'b1, REG_LINE_STAT, rnd[7:0] | 8'h01, q);
        acc(ch[0], 1'b0, REG_LINE_STAT, 8'h00, q);
        chk(q, 8'h00);
        irqReq[ch] <= 1'b1;
        acc(ch[0], 1'b1, REG_MODEM_CTL, 8'h08, q);
        chk({ch ? aux_out_b_n : aux_out_a_n, chan_a_irq_oe, chan_a_irq,
          chan_b_irq_oe, chan_b_irq},
          s ? (ch ? 5'h03 : 5'h0c) : 5'h08);
        chk(coreCtl[ch].modemCtl, 8'h08);
        irqReq[ch] <= 1'b0;
        acc(ch[0], 1'b1, REG_MODEM_CTL, 8'h00, q);
        chk({ch ? aux_out_b_n : aux_out_a_n, chan_a_irq_oe, chan_a_irq,
          chan_b_irq_oe, chan_b_irq}, 5'h10);
        rnd = lfsr(rnd);
        acc(ch[0], 1'b1, REG_DATA, rnd[7:0], q);
        txCnt[ch]++;
        chk(coreCtl[ch].txData, rnd[7:0]);
        repeat (3) @(posedge sys_clk);
        chk(ch ? tx_ready_b_n : tx_ready_a_n, txCnt[ch] != 0);
        // Ready mode with trigger code 3: tx ready while below depth
        acc(ch[0], 1'b1, REG_FIFO_CTL, 8'hc9, q);
        chk(coreCtl[ch].fifoCtl, 8'hc9);
        repeat (2) @(posedge sys_clk);
        chk(ch ? tx_ready_b_n : tx_ready_a_n, txCnt[ch] >= FIFO_DEPTH);
        chk(ch ? rx_ready_b_n : rx_ready_a_n, 1'b1);
        acc(ch[0], 1'b1, REG_FIFO_CTL, 8'h00, q);
        repeat (2) @(posedge sys_clk);
        rnd = lfsr(rnd);
        rxQ.push_back(rnd[7:0]);
        b <= rnd[7:0];
        rxLoad[ch] <= 1'b1;
        @(posedge sys_clk);
        rxLoad[ch] <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(ch ? rx_ready_b_n : rx_ready_a_n, 1'b0);
        acc(ch[0], 1'b0, REG_DATA, 8'h00, q);
        chk(q, rxQ.pop_front());
        chk(ch ? rx_ready_b_n : rx_ready_a_n, 1'b1);
      end
    end
    tally_and_finish();
  end
endmodule : dual_uart_host_bus_port_tb

`default_nettype wire
